// ---- verilog/gpci_port.sv ----
// module: eight-bit port with pull-ups, output latch and change interrupt
`timescale 1ns/1ps
`default_nettype none

module gpci_port (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register access
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // port pins
  input wire logic [7:0] port_level_bits_in,
  input wire logic [7:0] pin_is_input_in,
  output logic [7:0] latch_bits_out,
  output logic [7:0] weak_hold_high_bits_out,
  // interrupt pin
  output logic irq_pin_out,
  output logic irq_pin_oe_out
);

  // ==========================================================
  // register decode
  logic wr_pullup, wr_enable, wr_default, wr_select, wr_config;
  logic wr_port, wr_latch, qual_read;
  always_comb begin
    wr_enable = reg_write_in &&
        reg_addr_in == gpci_pkg::ADDR_CHANGE_IRQ_ENABLE;
    wr_default = reg_write_in &&
        reg_addr_in == gpci_pkg::ADDR_COMPARE_DEFAULT;
    wr_select = reg_write_in &&
        reg_addr_in == gpci_pkg::ADDR_COMPARE_SELECT;
    wr_config = reg_write_in &&
        reg_addr_in == gpci_pkg::ADDR_DEVICE_CONFIG;
    wr_pullup = reg_write_in &&
        reg_addr_in == gpci_pkg::ADDR_PULLUP_ENABLE;
    wr_port = reg_write_in && reg_addr_in == gpci_pkg::ADDR_PORT_VALUE;
    wr_latch = reg_write_in &&
        reg_addr_in == gpci_pkg::ADDR_OUTPUT_LATCH;
    qual_read = reg_read_in &&
        (reg_addr_in == gpci_pkg::ADDR_INTERRUPT_CAPTURE ||
         reg_addr_in == gpci_pkg::ADDR_PORT_VALUE);
  end

  // ==========================================================
  // configuration registers
  logic [7:0] change_irq_enable, compare_default, compare_select;
  logic [7:0] device_config, pullup_enable, output_latch;
  logic [7:0] next_change_irq_enable, next_compare_default;
  logic [7:0] next_compare_select, next_device_config;
  logic [7:0] next_pullup_enable, next_output_latch;
  always_comb begin
    next_change_irq_enable = wr_enable ? reg_wdata_in : change_irq_enable;
    next_compare_default = wr_default ? reg_wdata_in : compare_default;
    next_compare_select = wr_select ? reg_wdata_in : compare_select;
    next_device_config = wr_config ?
        (reg_wdata_in & gpci_pkg::CFG_WRITE_MASK) : device_config;
    next_pullup_enable = wr_pullup ? reg_wdata_in : pullup_enable;
    next_output_latch = output_latch;
    if (wr_port || wr_latch) begin
      next_output_latch = reg_wdata_in;
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      change_irq_enable <= gpci_pkg::RESET_BYTE;
      compare_default <= gpci_pkg::RESET_BYTE;
      compare_select <= gpci_pkg::RESET_BYTE;
      device_config <= gpci_pkg::RESET_BYTE;
      pullup_enable <= gpci_pkg::RESET_BYTE;
      output_latch <= gpci_pkg::RESET_BYTE;
    end else begin
      change_irq_enable <= next_change_irq_enable;
      compare_default <= next_compare_default;
      compare_select <= next_compare_select;
      device_config <= next_device_config;
      pullup_enable <= next_pullup_enable;
      output_latch <= next_output_latch;
    end
  end

  // ==========================================================
  // interrupt-on-change core
  logic [7:0] reference, interrupt_flags, interrupt_capture;
  logic [7:0] next_reference, next_interrupt_flags;
  logic [7:0] next_interrupt_capture;
  logic pending, next_pending;
  logic [7:0] cond, armed, prev_hits, mismatch, follow_pin;
  // per-pin compare and reference tracking
  for (genvar i = 0; i < gpci_pkg::PORT_WIDTH; i++) begin : g_pin
    assign mismatch[i] = compare_select[i] ?
        (port_level_bits_in[i] != compare_default[i]) :
        (port_level_bits_in[i] != reference[i]);
    assign follow_pin[i] = !(change_irq_enable[i] && pin_is_input_in[i]) ||
        (!compare_select[i] && !mismatch[i]);
  end
  always_comb begin
    armed = change_irq_enable & pin_is_input_in;
    cond = mismatch & armed;
    prev_hits = cond & ~compare_select;
    next_reference = (reference & ~follow_pin) |
        (port_level_bits_in & follow_pin);
    next_interrupt_flags = interrupt_flags;
    next_interrupt_capture = interrupt_capture;
    next_pending = pending;
    if (qual_read) begin
      next_pending = 1'b0;
      next_interrupt_flags = 8'h00;
    end
    if (cond != 8'h00) begin
      next_interrupt_flags = next_interrupt_flags | cond;
      next_reference = next_reference ^ prev_hits;
      if (!pending || qual_read) begin
        next_pending = 1'b1;
        next_interrupt_capture = port_level_bits_in;
      end
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reference <= gpci_pkg::RESET_BYTE;
      interrupt_flags <= gpci_pkg::RESET_BYTE;
      interrupt_capture <= gpci_pkg::RESET_BYTE;
      pending <= 1'b0;
    end else begin
      reference <= next_reference;
      interrupt_flags <= next_interrupt_flags;
      interrupt_capture <= next_interrupt_capture;
      pending <= next_pending;
    end
  end

  // ==========================================================
  // outputs
  logic [7:0] next_rdata, next_hold_high;
  logic next_irq, next_irq_oe;
  always_comb begin
    unique case (reg_addr_in)
      gpci_pkg::ADDR_CHANGE_IRQ_ENABLE: next_rdata = change_irq_enable;
      gpci_pkg::ADDR_COMPARE_DEFAULT: next_rdata = compare_default;
      gpci_pkg::ADDR_COMPARE_SELECT: next_rdata = compare_select;
      gpci_pkg::ADDR_DEVICE_CONFIG: next_rdata = device_config;
      gpci_pkg::ADDR_PULLUP_ENABLE: next_rdata = pullup_enable;
      gpci_pkg::ADDR_INTERRUPT_FLAGS: next_rdata = interrupt_flags;
      gpci_pkg::ADDR_INTERRUPT_CAPTURE: next_rdata = interrupt_capture;
      gpci_pkg::ADDR_PORT_VALUE: next_rdata = port_level_bits_in;
      gpci_pkg::ADDR_OUTPUT_LATCH: next_rdata = output_latch;
      default: next_rdata = 8'h00;
    endcase
    if (!reg_read_in) begin
      next_rdata = reg_rdata_out;
    end
    next_hold_high = pullup_enable & pin_is_input_in;
    if (device_config[gpci_pkg::CFG_OPEN_DRAIN_BIT]) begin
      next_irq = 1'b0;
      next_irq_oe = next_pending;
    end else begin
      next_irq = next_pending ~^
          device_config[gpci_pkg::CFG_POLARITY_BIT];
      next_irq_oe = 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
      latch_bits_out <= 8'h00;
      weak_hold_high_bits_out <= 8'h00;
      irq_pin_out <= 1'b1;
      irq_pin_oe_out <= 1'b1;
    end else begin
      reg_rdata_out <= next_rdata;
      latch_bits_out <= next_output_latch;
      weak_hold_high_bits_out <= next_hold_high;
      irq_pin_out <= next_irq;
      irq_pin_oe_out <= next_irq_oe;
    end
  end

  // ==========================================================
  // assertions and cover points
  a_flags_write_ignored: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (reg_write_in && reg_addr_in == gpci_pkg::ADDR_INTERRUPT_FLAGS &&
     !qual_read && cond == 8'h00) |=> $stable(interrupt_flags))
    else $error("flag register changed by write");
  a_capture_only_raise: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !$stable(interrupt_capture) |-> $rose(pending) ||
      (pending && $past(qual_read)))
    else $error("capture loaded without interrupt");
  a_capture_held: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (pending && !qual_read) |=> $stable(interrupt_capture))
    else $error("capture changed while pending");
  a_pending_held: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (pending && !qual_read) |=> pending)
    else $error("interrupt dropped without read");
  a_read_clears: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (qual_read && cond == 8'h00) |=> !pending)
    else $error("qualifying read did not clear");
  a_output_pins_quiet: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (!pending && (change_irq_enable & pin_is_input_in) == 8'h00)
      |=> !pending)
    else $error("interrupt from disabled pins");
  a_latch_write: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    wr_port |=> latch_bits_out == $past(reg_wdata_in))
    else $error("port write missed latch");
  a_pullup_inputs: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ##1 (weak_hold_high_bits_out & ~$past(pin_is_input_in)) == 8'h00)
    else $error("pull-up on output pin");
  a_pushpull_level: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !device_config[gpci_pkg::CFG_OPEN_DRAIN_BIT] && !wr_config
      |=> irq_pin_oe_out &&
      irq_pin_out == (pending ~^ device_config[gpci_pkg::CFG_POLARITY_BIT]))
    else $error("push-pull level wrong");
  c_raise: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(pending));
  c_second_event: cover property (@(posedge clk_in)
    disable iff (!reset_n_in) pending && cond != 8'h00);
  c_clear: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(pending));
  c_default_rearm: cover property (@(posedge clk_in)
    disable iff (!reset_n_in) qual_read && (cond & compare_select) != 8'h00);
  c_open_drain: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    device_config[gpci_pkg::CFG_OPEN_DRAIN_BIT] && pending);
  a_flags_enabled_only: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ##1 ((interrupt_flags & ~$past(interrupt_flags)) & ~$past(armed))
      == 8'h00)
    else $error("flag set for unarmed pin");
  a_flags_enable_gate: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ##1 ((interrupt_flags & ~$past(interrupt_flags)) &
      ~$past(change_irq_enable)) == 8'h00)
    else $error("flag set for disabled pin");
  a_flags_set_event: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (cond != 8'h00) |=> (interrupt_flags & $past(cond)) == $past(cond))
    else $error("event did not set flag");
  a_capture_kept_later: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (pending && !qual_read && cond != 8'h00) |=>
      $stable(interrupt_capture) && pending)
    else $error("later event reloaded capture");
  a_capture_loads_pins: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (!pending && cond != 8'h00) |=>
      interrupt_capture == $past(port_level_bits_in))
    else $error("capture missed pin levels");
  a_change_raises: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (prev_hits != 8'h00) |=> pending &&
      ((reference ^ $past(port_level_bits_in)) & $past(prev_hits)) == 8'h00)
    else $error("change did not raise or update reference");
  a_default_persists: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (qual_read && (cond & compare_select) != 8'h00) |=>
      pending && interrupt_flags != 8'h00)
    else $error("default mismatch lost on read");
  a_read_clears_flags: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (qual_read && cond == 8'h00) |=> interrupt_flags == 8'h00)
    else $error("flags kept after clearing read");
  a_opendrain_level: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (device_config[gpci_pkg::CFG_OPEN_DRAIN_BIT] && !wr_config) |=>
      !irq_pin_out && irq_pin_oe_out == pending)
    else $error("open-drain level wrong");
  a_port_read_pins: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (reg_read_in && reg_addr_in == gpci_pkg::ADDR_PORT_VALUE) |=>
      reg_rdata_out == $past(port_level_bits_in))
    else $error("port read not pin levels");
  a_latch_readback: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (reg_read_in && reg_addr_in == gpci_pkg::ADDR_OUTPUT_LATCH) |=>
      reg_rdata_out == $past(output_latch))
    else $error("latch read not latch contents");
  a_capture_readback: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (reg_read_in && reg_addr_in == gpci_pkg::ADDR_INTERRUPT_CAPTURE) |=>
      reg_rdata_out == $past(interrupt_capture))
    else $error("capture read wrong");

endmodule
`default_nettype wire

// ---- verilog/gpci_pkg.sv ----
// package: register map and reset values for the change-interrupt port
`default_nettype none
package gpci_pkg;
  localparam int REG_ADDR_WIDTH = 8;
  localparam int PORT_WIDTH = 8;
  // register offsets
  localparam logic [7:0] ADDR_CHANGE_IRQ_ENABLE = 8'h02;
  localparam logic [7:0] ADDR_COMPARE_DEFAULT = 8'h03;
  localparam logic [7:0] ADDR_COMPARE_SELECT = 8'h04;
  localparam logic [7:0] ADDR_DEVICE_CONFIG = 8'h05;
  localparam logic [7:0] ADDR_PULLUP_ENABLE = 8'h06;
  localparam logic [7:0] ADDR_INTERRUPT_FLAGS = 8'h07;
  localparam logic [7:0] ADDR_INTERRUPT_CAPTURE = 8'h08;
  localparam logic [7:0] ADDR_PORT_VALUE = 8'h09;
  localparam logic [7:0] ADDR_OUTPUT_LATCH = 8'h0A;
  // device_config field positions
  localparam int CFG_OPEN_DRAIN_BIT = 2;
  localparam int CFG_POLARITY_BIT = 1;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h3E;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage
`default_nettype wire

// ---- sim/gpci_host.sv ----
// host-side register access model for the port block
`timescale 1ns/1ps
`default_nettype none
module gpci_host (
  // clock
  input wire logic clk_in,
  // register access
  input wire logic [7:0] reg_rdata_in,
  output logic reg_write_out,
  output logic reg_read_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  // ==========
  // bus cycles, released lines show inverse data
  initial begin
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    reg_addr_out = 8'hFF;
    reg_wdata_out = 8'hFF;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_write_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clk_in);
    reg_write_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_read_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clk_in);
    reg_read_out <= 1'b0;
    reg_addr_out <= ~a;
    #1;
    d = reg_rdata_in;
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// testbench for the change-interrupt port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic rw, rr, irq, oe;
  logic [7:0] ra, rwd, rdata, latch, pull;
  logic [7:0] pins = 8'h00;
  logic [7:0] dir = 8'h3C;
  int num_errors = 0;
  int compares = 0;
  always #2 clk_in = ~clk_in;
  gpci_host host (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_write_out(rw),
    .reg_read_out(rr), .reg_addr_out(ra), .reg_wdata_out(rwd));
  gpci_port DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_write_in(rw), .reg_read_in(rr), .reg_addr_in(ra),
    .reg_wdata_in(rwd), .reg_rdata_out(rdata), .port_level_bits_in(pins),
    .pin_is_input_in(dir), .latch_bits_out(latch),
    .weak_hold_high_bits_out(pull), .irq_pin_out(irq), .irq_pin_oe_out(oe));
  // ==========
  // helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk("read", e, d);
  endtask
  task automatic wt();
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic setp(input logic [7:0] p);
    @(posedge clk_in);
    pins <= p;
    wt();
  endtask
  task automatic ichk(input logic o, input logic en);
    wt();
    chk("irq_pin", {6'h00, o, en}, {6'h00, irq, oe});
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    rchk(gpci_pkg::ADDR_PULLUP_ENABLE, 8'h00);
    host.wr(gpci_pkg::ADDR_PULLUP_ENABLE, 8'hF0);
    wt();
    chk("pullups", 8'h30, pull);
    host.wr(gpci_pkg::ADDR_OUTPUT_LATCH, 8'hA5);
    rchk(gpci_pkg::ADDR_OUTPUT_LATCH, 8'hA5);
    chk("latch", 8'hA5, latch);
    host.wr(gpci_pkg::ADDR_PORT_VALUE, 8'h3C);
    setp(8'h81);
    chk("latch", 8'h3C, latch);
    rchk(gpci_pkg::ADDR_PORT_VALUE, 8'h81);
    rchk(gpci_pkg::ADDR_OUTPUT_LATCH, 8'h3C);
    host.wr(gpci_pkg::ADDR_INTERRUPT_FLAGS, 8'hFF);
    rchk(gpci_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
    rchk(8'h1F, 8'h00);
    host.wr(gpci_pkg::ADDR_DEVICE_CONFIG, 8'hFF);
    rchk(gpci_pkg::ADDR_DEVICE_CONFIG, 8'h3E);
  endtask
  task automatic t_prev();
    @(posedge clk_in);
    dir <= 8'h0F;
    setp(8'h00);
    host.wr(gpci_pkg::ADDR_DEVICE_CONFIG, 8'h02);
    host.wr(gpci_pkg::ADDR_CHANGE_IRQ_ENABLE, 8'hFF);
    setp(8'h80);
    ichk(1'b0, 1'b1);
    setp(8'h81);
    ichk(1'b1, 1'b1);
    setp(8'h83);
    rchk(gpci_pkg::ADDR_INTERRUPT_FLAGS, 8'h03);
    host.wr(gpci_pkg::ADDR_INTERRUPT_CAPTURE, 8'h55);
    host.wr(gpci_pkg::ADDR_PORT_VALUE, 8'h00);
    ichk(1'b1, 1'b1);
    rchk(gpci_pkg::ADDR_INTERRUPT_CAPTURE, 8'h81);
    ichk(1'b0, 1'b1);
    rchk(gpci_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
    setp(8'h82);
    ichk(1'b1, 1'b1);
    rchk(gpci_pkg::ADDR_PORT_VALUE, 8'h82);
    ichk(1'b0, 1'b1);
  endtask
  task automatic t_dflt();
    host.wr(gpci_pkg::ADDR_COMPARE_DEFAULT, 8'h00);
    host.wr(gpci_pkg::ADDR_COMPARE_SELECT, 8'h0F);
    ichk(1'b1, 1'b1);
    rchk(gpci_pkg::ADDR_INTERRUPT_CAPTURE, 8'h82);
    ichk(1'b1, 1'b1);
    setp(8'h80);
    rchk(gpci_pkg::ADDR_PORT_VALUE, 8'h80);
    ichk(1'b0, 1'b1);
    host.wr(gpci_pkg::ADDR_CHANGE_IRQ_ENABLE, 8'h00);
    setp(8'h8F);
    ichk(1'b0, 1'b1);
    rchk(gpci_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
    host.wr(gpci_pkg::ADDR_CHANGE_IRQ_ENABLE, 8'h0F);
    host.wr(gpci_pkg::ADDR_DEVICE_CONFIG, 8'h06);
    ichk(1'b0, 1'b1);
    host.wr(gpci_pkg::ADDR_DEVICE_CONFIG, 8'h00);
    ichk(1'b0, 1'b1);
    setp(8'h80);
    rchk(gpci_pkg::ADDR_INTERRUPT_CAPTURE, 8'h8F);
    ichk(1'b1, 1'b1);
    host.wr(gpci_pkg::ADDR_DEVICE_CONFIG, 8'h04);
    ichk(1'b0, 1'b0);
  endtask
  // ==========
  // run control
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    #1;
    chk("latch", 8'h00, latch);
    ichk(1'b1, 1'b1);
    t_regs();
    t_prev();
    t_dflt();
    tally_and_finish();
  end
endmodule
`default_nettype wire
